// [hdl/ccfg_top.sv]
// Control channel I2C configuration, watchdog, remap and error counters
`timescale 1ns/1ns
`default_nettype none
`include "ccfg_defs.svh"

module ccfg_top
  import ccfg_pkg::*;
#(
  parameter logic [25:0] WD_SLOW_CYC = 26'(`CCFG_WD_SLOW_CYC)
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Register access from the serial control bus
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_from_remote,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_wr_refused,
  // Per-port selection
  input wire logic second_port_select,
  // Link status and channel events, one entry per port
  input wire logic [1:0] rx_lock,
  input wire logic [1:0] remote_id_valid,
  input wire logic [1:0][6:0] remote_id,
  input wire logic [1:0] check_fail,
  // Transaction address lookup
  input wire logic txn_start,
  input wire logic txn_port,
  input wire logic [6:0] txn_addr,
  input wire logic txn_bad_end,
  output logic fwd_valid,
  output logic fwd_des,
  output logic fwd_port,
  output logic [6:0] fwd_addr,
  output logic fwd_miss,
  // SDA drive request from the slave engine
  input wire logic sda_req,
  // Open-drain bus pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Watchdog results
  output logic bus_free,
  output logic bus_recovered
);

  ccfg_state_type st_ff;
  ccfg_state_type nxt_st;
  logic wd_pull;
  logic wd_free;
  logic wd_recov;
  logic psel;
  logic wr_ok;

  // Nonzero reference address that equals the requested one
  function automatic logic addr_hit(input logic [6:0] a,
                                    input logic [6:0] ref_addr);
    addr_hit = (ref_addr != 7'h00) && (a == ref_addr);
  endfunction

  // Delay cycles for an SDA delay code
  function automatic logic [4:0] sda_delay(input logic [1:0] code);
    sda_delay = 5'(`CCFG_SDA_BASE_CYC) +
                5'(code) * 5'(`CCFG_SDA_STEP_CYC);
  endfunction

  // Register read value for one address and port
  function automatic logic [7:0] rd_mux(input ccfg_state_type s,
                                       input logic [7:0] a,
                                       input logic p);
    rd_mux = 8'h00;
    case (a)
      `CCFG_ADDR_GEN_CFG: begin
        rd_mux[`CCFG_PASS_BIT] = s.pass_en[p];
      end
      `CCFG_ADDR_MODE: begin
        rd_mux[`CCFG_CNT_CLR_BIT] = s.cnt_clr;
      end
      `CCFG_ADDR_I2C_CTRL: begin
        rd_mux[`CCFG_SDA_DLY_HI:`CCFG_SDA_DLY_LO] = s.sda_dly;
        rd_mux[`CCFG_LWD_BIT] = s.lwd;
        rd_mux[`CCFG_WD_FAST_BIT] = s.wd_fast;
        rd_mux[`CCFG_WD_OFF_BIT] = s.wd_off;
      end
      `CCFG_ADDR_DES: begin
        rd_mux[`CCFG_ID_HI:`CCFG_ID_LO] = s.des_addr[p];
        rd_mux[`CCFG_FREEZE_BIT] = s.freeze[p];
      end
      `CCFG_ADDR_SLV: begin
        rd_mux[`CCFG_ID_HI:`CCFG_ID_LO] = s.slv_addr[p];
      end
      `CCFG_ADDR_ALIAS: begin
        rd_mux[`CCFG_ID_HI:`CCFG_ID_LO] = s.slv_alias[p];
      end
      `CCFG_ADDR_FAIL_LO: begin
        rd_mux = s.fail_cnt[p][7:0];
      end
      `CCFG_ADDR_FAIL_HI: begin
        rd_mux = s.fail_cnt[p][15:8];
      end
      // Reserved and unmapped offsets read as zero
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  endfunction

  // Next error count: clear wins over an event, and the count saturates
  // so a long error storm never wraps round to a small value
  function automatic logic [15:0] count_next(input logic [15:0] c,
                                             input logic clr,
                                             input logic ev);
    if (clr) begin
      count_next = 16'h0000;
    end else if (ev && c != 16'hffff) begin
      count_next = c + 16'h0001;
    end else begin
      count_next = c;
    end
  endfunction

  // Alias remap needs pass-through on that port and both addresses set;
  // a zero in either register turns the remap off
  function automatic logic alias_hit(input ccfg_state_type s,
                                     input logic p,
                                     input logic [6:0] a);
    alias_hit = s.pass_en[p] && addr_hit(a, s.slv_alias[p]) &&
                (s.slv_addr[p] != 7'h00);
  endfunction

  // The watchdog keeps its own pin history and only wakes on a bad end
  ccfg_watchdog #(
    .SLOW_CYC(WD_SLOW_CYC)
  ) u_watchdog (
    .core_clk(core_clk),
    .srst(srst),
    .wd_off(st_ff.wd_off),
    .wd_fast(st_ff.wd_fast),
    .bad_end(txn_bad_end),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_pull(wd_pull),
    .bus_free(wd_free),
    .recovered(wd_recov)
  );

  always_comb begin
    nxt_st = st_ff;
    psel = second_port_select;
    nxt_st.wr_refused = 1'b0;
    nxt_st.fwd_valid = 1'b0;
    nxt_st.fwd_miss = 1'b0;
    nxt_st.od_level = 1'b0;

    // Channel events first so that a register write in the same cycle wins
    // Each port keeps its own fields; the port select only steers the bus
    for (int p = 0; p < 2; p++) begin
      if (rx_lock[p] && remote_id_valid[p] && !st_ff.freeze[p]) begin
        nxt_st.des_addr[p] = remote_id[p];
      end
      nxt_st.fail_cnt[p] = count_next(st_ff.fail_cnt[p], st_ff.cnt_clr,
                                      check_fail[p]);
    end

    // Writes arriving over the control channel may be locked out
    wr_ok = reg_wr && !(reg_from_remote && st_ff.lwd);
    if (reg_wr && !wr_ok) begin
      nxt_st.wr_refused = 1'b1;
    end
    if (wr_ok) begin
      case (reg_addr)
        `CCFG_ADDR_GEN_CFG: begin
          nxt_st.pass_en[psel] = reg_wdata[`CCFG_PASS_BIT];
        end
        `CCFG_ADDR_MODE: begin
          nxt_st.cnt_clr = reg_wdata[`CCFG_CNT_CLR_BIT];
        end
        `CCFG_ADDR_I2C_CTRL: begin
          nxt_st.sda_dly =
            reg_wdata[`CCFG_SDA_DLY_HI:`CCFG_SDA_DLY_LO];
          nxt_st.lwd = reg_wdata[`CCFG_LWD_BIT];
          nxt_st.wd_fast = reg_wdata[`CCFG_WD_FAST_BIT];
          nxt_st.wd_off = reg_wdata[`CCFG_WD_OFF_BIT];
        end
        `CCFG_ADDR_DES: begin
          nxt_st.des_addr[psel] =
            reg_wdata[`CCFG_ID_HI:`CCFG_ID_LO];
          nxt_st.freeze[psel] = reg_wdata[`CCFG_FREEZE_BIT];
        end
        `CCFG_ADDR_SLV: begin
          nxt_st.slv_addr[psel] = reg_wdata[`CCFG_ID_HI:`CCFG_ID_LO];
        end
        `CCFG_ADDR_ALIAS: begin
          nxt_st.slv_alias[psel] = reg_wdata[`CCFG_ID_HI:`CCFG_ID_LO];
        end
        `CCFG_ADDR_FAIL_LO, `CCFG_ADDR_FAIL_HI: begin
          // The counters are read-only; a write to them is dropped
          nxt_st.wr_refused = 1'b0;
        end
        default: begin
          nxt_st.wr_refused = 1'b0;
        end
      endcase
    end

    // Read data registered one cycle after the read strobe
    if (reg_rd) begin
      nxt_st.rdata = rd_mux(st_ff, reg_addr, psel);
    end

    // Address lookup; the local write lock plays no part here
    if (txn_start) begin
      // Alias remap is tried before the deserializer address
      if (alias_hit(st_ff, txn_port, txn_addr)) begin
        nxt_st.fwd_valid = 1'b1;
        nxt_st.fwd_des = 1'b0;
        nxt_st.fwd_addr = st_ff.slv_addr[txn_port];
        nxt_st.fwd_port = txn_port;
      end else if (addr_hit(txn_addr, st_ff.des_addr[txn_port])) begin
        nxt_st.fwd_valid = 1'b1;
        nxt_st.fwd_des = 1'b1;
        nxt_st.fwd_addr = st_ff.des_addr[txn_port];
        nxt_st.fwd_port = txn_port;
      end else begin
        nxt_st.fwd_miss = 1'b1;
      end
    end

    // SDA output delay counted from each falling SCL edge; a fresh fall
    // restarts the count, so a second fall before the count ends delays the change
    nxt_st.scl_prev = scl_in;
    if (st_ff.scl_prev && !scl_in) begin
      nxt_st.sda_cnt = sda_delay(st_ff.sda_dly);
    end else if (st_ff.sda_cnt != 5'h00) begin
      nxt_st.sda_cnt = st_ff.sda_cnt - 5'h01;
      if (st_ff.sda_cnt == 5'h01) begin
        nxt_st.sda_pull = ~sda_req;
      end
    end

    // Registered again so the pin enable comes from this module's flop
    nxt_st.scl_pull = wd_pull;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Register port
  assign reg_rdata = st_ff.rdata;
  assign reg_wr_refused = st_ff.wr_refused;

  // Lookup results
  assign fwd_valid = st_ff.fwd_valid;
  assign fwd_des = st_ff.fwd_des;
  assign fwd_port = st_ff.fwd_port;
  assign fwd_addr = st_ff.fwd_addr;
  assign fwd_miss = st_ff.fwd_miss;
  // Open drain: the level is always low, the enable says when to pull
  assign scl_out = st_ff.od_level;
  assign scl_oe_n = ~st_ff.scl_pull;
  assign sda_out = st_ff.od_level;
  assign sda_oe_n = ~st_ff.sda_pull;

  // Watchdog results
  assign bus_free = wd_free;
  assign bus_recovered = wd_recov;

endmodule // ccfg_top
`default_nettype wire

// [hdl/ccfg_defs.svh]
// Register map, field positions and timing counts of the control channel
`ifndef CCFG_DEFS_SVH
`define CCFG_DEFS_SVH

// Register offsets
`define CCFG_ADDR_GEN_CFG 8'h03
`define CCFG_ADDR_MODE 8'h04
`define CCFG_ADDR_I2C_CTRL 8'h05
`define CCFG_ADDR_DES 8'h06
`define CCFG_ADDR_SLV 8'h07
`define CCFG_ADDR_ALIAS 8'h08
`define CCFG_ADDR_FAIL_LO 8'h0a
`define CCFG_ADDR_FAIL_HI 8'h0b

// Field positions
`define CCFG_PASS_BIT 3
`define CCFG_CNT_CLR_BIT 5
`define CCFG_SDA_DLY_HI 4
`define CCFG_SDA_DLY_LO 3
`define CCFG_LWD_BIT 2
`define CCFG_WD_FAST_BIT 1
`define CCFG_WD_OFF_BIT 0
`define CCFG_FREEZE_BIT 0
`define CCFG_ID_HI 7
`define CCFG_ID_LO 1

// Clock
`define CCFG_CLK_HZ 50000000
`define CCFG_CLK_NS 20

// SDA output delay: base and per-code step
`define CCFG_SDA_BASE_NS 240
`define CCFG_SDA_STEP_NS 40
`define CCFG_SDA_BASE_CYC (`CCFG_SDA_BASE_NS / `CCFG_CLK_NS)
`define CCFG_SDA_STEP_CYC (`CCFG_SDA_STEP_NS / `CCFG_CLK_NS)

// Bus watchdog intervals
`define CCFG_WD_SLOW_S 1
`define CCFG_WD_FAST_US 50
`define CCFG_WD_SLOW_CYC (`CCFG_CLK_HZ * `CCFG_WD_SLOW_S)
`define CCFG_WD_FAST_CYC ((`CCFG_CLK_HZ / 1000000) * `CCFG_WD_FAST_US)

// Recovery clock: half period and pulse count
`define CCFG_RECOV_HALF_NS 5000
`define CCFG_RECOV_HALF_CYC (`CCFG_RECOV_HALF_NS / `CCFG_CLK_NS)
`define CCFG_RECOV_PULSES 9

`endif

// [hdl/ccfg_pkg.sv]
// Types shared by the control channel configuration logic
package ccfg_pkg;

  typedef enum logic [1:0] {
    WD_IDLE = 2'b00,
    WD_WATCH = 2'b01,
    WD_RECOVER = 2'b10
  } ccfg_wd_state_type;

  typedef struct packed {
    ccfg_wd_state_type state;
    logic [25:0] cnt;
    logic [3:0] pulses;
    logic scl_pull;
    logic bus_free;
    logic recovered;
    logic scl_prev;
    logic sda_prev;
  } ccfg_wd_type;

  typedef struct packed {
    logic [1:0] sda_dly;
    logic lwd;
    logic wd_fast;
    logic wd_off;
    logic [1:0][6:0] des_addr;
    logic [1:0] freeze;
    logic [1:0][6:0] slv_addr;
    logic [1:0][6:0] slv_alias;
    logic [1:0][15:0] fail_cnt;
    logic cnt_clr;
    logic [1:0] pass_en;
    logic [7:0] rdata;
    logic wr_refused;
    logic fwd_valid;
    logic fwd_des;
    logic fwd_port;
    logic [6:0] fwd_addr;
    logic fwd_miss;
    logic scl_prev;
    logic [4:0] sda_cnt;
    logic sda_pull;
    logic scl_pull;
    logic od_level;
  } ccfg_state_type;

endpackage

// [hdl/ccfg_watchdog.sv]
// I2C bus watchdog: detects a free or hung bus and clocks it free
`timescale 1ns/1ns
`default_nettype none
`include "ccfg_defs.svh"

module ccfg_watchdog
  import ccfg_pkg::*;
#(
  parameter logic [25:0] SLOW_CYC = 26'(`CCFG_WD_SLOW_CYC)
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Control
  input wire logic wd_off,
  input wire logic wd_fast,
  input wire logic bad_end,
  // Bus lines as seen on the pins
  input wire logic scl_in,
  input wire logic sda_in,
  // Results
  output logic scl_pull,
  output logic bus_free,
  output logic recovered
);

  ccfg_wd_type st_ff;
  ccfg_wd_type nxt_st;
  logic [25:0] limit;
  logic quiet;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.bus_free = 1'b0;
    nxt_st.recovered = 1'b0;
    nxt_st.scl_prev = scl_in;
    nxt_st.sda_prev = sda_in;
    limit = wd_fast ? 26'(`CCFG_WD_FAST_CYC) : SLOW_CYC;
    // Any change on SCL or SDA counts as bus activity, own SCL pulses included
    quiet = (scl_in == st_ff.scl_prev) && (sda_in == st_ff.sda_prev);
    case (st_ff.state)
      WD_IDLE: begin
        nxt_st.scl_pull = 1'b0;
        nxt_st.cnt = '0;
        if (bad_end) begin
          nxt_st.state = WD_WATCH;
        end
      end
      WD_WATCH: begin
        if (!quiet) begin
          nxt_st.cnt = '0;
        end else if (st_ff.cnt + 26'h1 >= limit) begin
          nxt_st.cnt = '0;
          if (sda_in) begin
            nxt_st.bus_free = 1'b1;
            nxt_st.state = WD_IDLE;
          end else begin
            nxt_st.state = WD_RECOVER;
            nxt_st.pulses = '0;
            nxt_st.scl_pull = 1'b1;
          end
        end else begin
          nxt_st.cnt = st_ff.cnt + 26'h1;
        end
      end
      WD_RECOVER: begin
        if (st_ff.cnt + 26'h1 >= 26'(`CCFG_RECOV_HALF_CYC)) begin
          nxt_st.cnt = '0;
          nxt_st.scl_pull = ~st_ff.scl_pull;
          if (st_ff.scl_pull) begin
            nxt_st.pulses = st_ff.pulses + 4'h1;
            if (st_ff.pulses + 4'h1 == 4'(`CCFG_RECOV_PULSES)) begin
              nxt_st.state = WD_IDLE;
              nxt_st.recovered = 1'b1;
            end
          end
        end else begin
          nxt_st.cnt = st_ff.cnt + 26'h1;
        end
      end
      default: begin
        nxt_st.state = WD_IDLE;
        nxt_st.scl_pull = 1'b0;
      end
    endcase
    if (wd_off) begin
      nxt_st.state = WD_IDLE;
      nxt_st.scl_pull = 1'b0;
      nxt_st.cnt = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign scl_pull = st_ff.scl_pull;
  assign bus_free = st_ff.bus_free;
  assign recovered = st_ff.recovered;

endmodule // ccfg_watchdog
`default_nettype wire

// [testbench/ccfg_top_properties.sv]
// Port assertions for the control channel configuration block
`timescale 1ns/1ns
`default_nettype none
module ccfg_props (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Register and lookup ports
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic reg_from_remote,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_wr_refused,
  input wire logic txn_start,
  input wire logic txn_bad_end,
  input wire logic fwd_valid,
  input wire logic fwd_miss,
  // Bus pins and watchdog
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic scl_out,
  input wire logic scl_oe_n,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic bus_free,
  input wire logic bus_recovered
);
  logic scl_d_ff, sda_d_ff, oe_d_ff;
  logic [4:0] fall_ff;
  logic [11:0] quiet_ff;
  logic [8:0] low_ff;
  logic [3:0] npulse_ff;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // fall_ff and quiet_ff saturate so long idle stretches never wrap into a false pass
  always_ff @(posedge core_clk) begin
    scl_d_ff <= scl_in;
    sda_d_ff <= sda_in;
    oe_d_ff <= scl_oe_n;
    if (srst) fall_ff <= 5'h1f;
    else if (scl_d_ff && !scl_in) fall_ff <= 5'h00;
    else if (fall_ff != 5'h1f) fall_ff <= fall_ff + 5'h01;
    if (srst || scl_in != scl_d_ff || sda_in != sda_d_ff) quiet_ff <= '0;
    else if (quiet_ff != 12'hfff) quiet_ff <= quiet_ff + 12'h001;
    low_ff <= scl_oe_n ? 9'h000 : low_ff + 9'h001;
    if (srst || txn_bad_end) npulse_ff <= 4'h0;
    else if (oe_d_ff && !scl_oe_n) npulse_ff <= npulse_ff + 4'h1;
  end
  property p_refuse;
    reg_wr_refused |-> $past(reg_wr && reg_from_remote);
  endproperty
  a_refuse: assert property (p_refuse) else $error("stray refusal");
  property p_answer;
    txn_start |=> (fwd_valid != fwd_miss);
  endproperty
  a_answer: assert property (p_answer) else $error("no lookup answer");
  property p_no_spur;
    (fwd_valid || fwd_miss) |-> $past(txn_start);
  endproperty
  a_no_spur: assert property (p_no_spur) else $error("stray answer");
  property p_rdata_hold;
    !$past(reg_rd) |-> $stable(reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");
  property p_sda_delay;
    $changed(sda_oe_n) |-> fall_ff >= 5'd12 && fall_ff <= 5'd18;
  endproperty
  a_sda_delay: assert property (p_sda_delay) else $error("sda timing");
  property p_free;
    bus_free |-> quiet_ff >= 12'd2500 && sda_in;
  endproperty
  a_free: assert property (p_free) else $error("early bus free");
  property p_low_len;
    $rose(scl_oe_n) |-> low_ff == 9'd250;
  endproperty
  a_low_len: assert property (p_low_len) else $error("scl pulse width");
  property p_nine;
    bus_recovered |-> npulse_ff == 4'd9;
  endproperty
  a_nine: assert property (p_nine) else $error("pulse count");
  property p_drive;
    scl_out == 1'b0 && sda_out == 1'b0;
  endproperty
  a_drive: assert property (p_drive) else $error("pin driven high");
endmodule // ccfg_props
bind ccfg_top ccfg_props u_props (.core_clk, .srst, .reg_rd, .reg_wr,
  .reg_from_remote, .reg_rdata, .reg_wr_refused, .txn_start, .txn_bad_end,
  .fwd_valid, .fwd_miss, .scl_in, .sda_in, .scl_out, .scl_oe_n, .sda_out,
  .sda_oe_n, .bus_free, .bus_recovered);
`default_nettype wire

// [testbench/ccfg_far.sv]
// Far-side model: channel events and pulled-up bus lines
`timescale 1ns/1ns
`default_nettype none
module ccfg_far (
  // Clock
  input wire logic core_clk,
  // Drive from the block
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  // Pin levels and channel events
  output logic scl_in,
  output logic sda_in,
  output logic [1:0] rx_lock,
  output logic [1:0] remote_id_valid,
  output logic [1:0][6:0] remote_id,
  output logic [1:0] check_fail
);
  logic scl_hold = 1'b0;
  logic sda_hold = 1'b0;
  // Pull-ups: a line is low only while some party pulls it
  assign scl_in = scl_oe_n & ~scl_hold;
  assign sda_in = sda_oe_n & ~sda_hold;
  initial begin
    rx_lock = 2'h0;
    remote_id_valid = 2'h0;
    remote_id = '0;
    check_fail = 2'h0;
  end
  // Lone pulses, so each failure lands on exactly one edge
  task automatic fail(input int p, input int n);
    repeat (n) begin
      check_fail[p] = 1'b1;
      @(posedge core_clk);
      #1 check_fail[p] = 1'b0;
      @(posedge core_clk);
      #1;
    end
  endtask
  task automatic send_id(input int p, input logic [6:0] id);
    rx_lock[p] = 1'b1;
    remote_id[p] = id;
    remote_id_valid[p] = 1'b1;
    @(posedge core_clk);
    #1 remote_id_valid[p] = 1'b0;
    // Stale value is not kept once the strobe is gone
    remote_id[p] = ~id;
    @(posedge core_clk);
    #1;
  endtask
endmodule // ccfg_far
`default_nettype wire

// [testbench/test_control_channel_i2c_cfg.sv]
// Self-checking bench for the control channel configuration block
`timescale 1ns/1ns
`default_nettype none
module test_control_channel_i2c_cfg;
  logic core_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, reg_from_remote = 0;
  logic second_port_select = 0, txn_start = 0, txn_port = 0;
  logic txn_bad_end = 0, sda_req = 1, ref_seen, fwd_port;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
  logic [6:0] txn_addr = 0, fwd_addr;
  logic reg_wr_refused, fwd_valid, fwd_des, fwd_miss, scl_in, scl_out;
  logic scl_oe_n, sda_in, sda_out, sda_oe_n, bus_free, bus_recovered;
  logic [1:0] rx_lock, remote_id_valid, check_fail;
  logic [1:0][6:0] remote_id;
  int n_errors = 0, comparisons = 0, k, nf;
  // Short slow interval keeps the watchdog runs brief
  ccfg_top #(.WD_SLOW_CYC(26'd3000)) dut (.core_clk, .srst, .reg_wr,
    .reg_rd, .reg_from_remote, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_wr_refused, .second_port_select, .rx_lock, .remote_id_valid,
    .remote_id, .check_fail, .txn_start, .txn_port, .txn_addr, .txn_bad_end,
    .fwd_valid, .fwd_des, .fwd_port, .fwd_addr, .fwd_miss, .sda_req,
    .scl_in, .scl_out, .scl_oe_n, .sda_in, .sda_out, .sda_oe_n, .bus_free,
    .bus_recovered);
  ccfg_far far (.core_clk, .scl_oe_n, .sda_oe_n, .scl_in, .sda_in,
    .rx_lock, .remote_id_valid, .remote_id, .check_fail);
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  task automatic chk(input string n, input logic [15:0] e, g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, d, input logic rem = 1'b0);
    reg_addr = a;
    reg_wdata = d;
    reg_from_remote = rem;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    reg_from_remote = 1'b0;
    ref_seen = reg_wr_refused;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, e);
    reg_addr = a;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, reg_rdata});
    tick(1);
  endtask
  task automatic look(input logic p, input logic [6:0] a, input logic hit,
                      input logic des, input logic [6:0] ra);
    txn_port = p;
    txn_addr = a;
    txn_start = 1'b1;
    tick(1);
    txn_start = 1'b0;
    chk("fwd", {14'h0, hit, !hit}, {14'h0, fwd_valid, fwd_miss});
    if (hit) chk("dst", {7'h0, p, des, ra}, {7'h0, fwd_port, fwd_des, fwd_addr});
    tick(1);
  endtask
  task automatic watch(input int lim, input logic poke, must);
    logic prev;
    prev = scl_oe_n;
    k = 0;
    nf = 0;
    txn_bad_end = 1'b1;
    tick(1);
    txn_bad_end = 1'b0;
    while (!(bus_free || bus_recovered) && k < lim) begin
      far.scl_hold = poke && k == 1000;
      tick(1);
      k++;
      nf += int'(prev && !scl_oe_n);
      prev = scl_oe_n;
    end
    if (must && k >= lim) begin
      chk("wait", 16'h0, 16'h1);
      end_of_test();
    end
  endtask
  task automatic t_regs;
    for (int a = 3; a < 12; a++) rd(8'(a), 8'h00);
    wr(8'h05, 8'hff);
    rd(8'h05, 8'h1f);
    wr(8'h0a, 8'h5a);
    rd(8'h0a, 8'h00);
    rd(8'h20, 8'h00);
    wr(8'h05, 8'h00);
    $display("done regs");
  endtask
  task automatic t_remap;
    wr(8'h07, 8'h24);
    wr(8'h08, 8'h68);
    look(0, 7'h34, 0, 0, 0);
    wr(8'h03, 8'h08);
    look(0, 7'h34, 1, 0, 7'h12);
    look(1, 7'h34, 0, 0, 0);
    wr(8'h07, 8'h00);
    look(0, 7'h34, 0, 0, 0);
    wr(8'h06, 8'h55);
    look(0, 7'h2a, 1, 1, 7'h2a);
    wr(8'h06, 8'h01);
    look(0, 7'h00, 0, 0, 0);
    wr(8'h05, 8'h04);
    wr(8'h06, 8'h55, 1);
    chk("refused", 16'h1, 16'(ref_seen));
    rd(8'h06, 8'h01);
    wr(8'h06, 8'h55);
    chk("refused", 16'h0, 16'(ref_seen));
    look(0, 7'h2a, 1, 1, 7'h2a);
    wr(8'h05, 8'h00);
    wr(8'h06, 8'h57, 1);
    rd(8'h06, 8'h57);
    $display("done remap");
  endtask
  task automatic t_auto;
    second_port_select = 1'b1;
    far.send_id(1, 7'h33);
    rd(8'h06, 8'h66);
    wr(8'h06, 8'h2b);
    far.send_id(1, 7'h44);
    rd(8'h06, 8'h2b);
    second_port_select = 1'b0;
    rd(8'h06, 8'h57);
    far.fail(0, 3);
    far.fail(1, 257);
    rd(8'h0a, 8'h03);
    rd(8'h0b, 8'h00);
    second_port_select = 1'b1;
    rd(8'h0a, 8'h01);
    rd(8'h0b, 8'h01);
    second_port_select = 1'b0;
    wr(8'h04, 8'h20);
    far.fail(0, 2);
    rd(8'h0a, 8'h00);
    wr(8'h04, 8'h00);
    far.fail(0, 1);
    rd(8'h0a, 8'h01);
    $display("done channel");
  endtask
  task automatic t_bus;
    logic o;
    for (int c = 0; c < 4; c++) begin
      wr(8'h05, 8'(c << 3));
      sda_req = ~sda_req;
      o = sda_oe_n;
      far.scl_hold = 1'b1;
      // The fall is seen at the next edge; the delay counts from there
      tick(1);
      k = 0;
      while (sda_oe_n === o && k < 40) begin
        tick(1);
        k++;
      end
      chk("sda_dly", 16'(12 + 2 * c), 16'(k));
      far.scl_hold = 1'b0;
      tick(20);
    end
    wr(8'h05, 8'h03);
    far.sda_hold = 1'b1;
    watch(3000, 1'b0, 1'b0);
    chk("off", 16'h0, 16'(nf));
    wr(8'h05, 8'h02);
    watch(8000, 1'b0, 1'b1);
    chk("pulses", 16'd9, 16'(nf));
    chk("recov_t", 16'h1, 16'(k >= 6750 && k <= 7020));
    far.sda_hold = 1'b0;
    wr(8'h05, 8'h00);
    watch(5000, 1'b1, 1'b1);
    chk("free", 16'h1, 16'(bus_free));
    chk("free_t", 16'h1, 16'(k >= 4000 && k <= 4010));
    $display("done bus");
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    #1 srst = 1'b0;
    t_regs();
    t_remap();
    t_auto();
    t_bus();
    end_of_test();
  end
endmodule // test_control_channel_i2c_cfg
`default_nettype wire
